/* File: rtl/divdly_refdet_pkg.sv */
// Constants, field layout and detector codes for the divider delay / reference detect bank
package divdly_refdet_pkg;
  localparam logic [7:0] DELAY_EN_OFS = 8'h18;
  localparam logic [7:0] REF_DET_OFS = 8'h19;
  localparam logic [7:0] REF_STATUS_OFS = 8'h1A;
  localparam int DIV_COUNT = 6;
  localparam int DIV_VALUE_W = 8;
  localparam logic [7:0] MARGIN_MIN_DIV = 8'h08;
  localparam logic [5:0] DELAY_EN_RESET = 6'h00;
  localparam int SEC_METHOD_LSB = 6;
  localparam int PRI_METHOD_LSB = 4;
  localparam logic [1:0] METHOD_RESET = 2'h1;
  localparam int PRI_PRESENT_BIT = 0;
  localparam int SEC_PRESENT_BIT = 1;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DET_WINDOW_NS = 512;
  localparam int DET_WINDOW_CYC = (DET_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DET_TIMER_W = 7;
  typedef enum logic [1:0] {
    DET_RISE = 2'b00,
    DET_BOTH = 2'b01,
    DET_FALL = 2'b10,
    DET_LEVEL = 2'b11
  } det_method_t;
endpackage

/* File: rtl/ref_activity_detector.sv */
// Activity detector for one single-ended reference input
`timescale 1ns/1ps
module ref_activity_detector import divdly_refdet_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic ref_level,
  input wire logic [1:0] method,
  output logic present
);
  logic prev_ff;
  logic seen_hi_ff;
  logic seen_lo_ff;
  logic [DET_TIMER_W-1:0] timer_ff;
  logic present_ff;
  wire rise = ref_level & ~prev_ff;
  wire fall = ~ref_level & prev_ff;
  wire both_levels = (seen_hi_ff | ref_level) & (seen_lo_ff | ~ref_level);
  logic activity;
  always_comb begin
    case (det_method_t'(method))
      DET_RISE: activity = rise;
      DET_BOTH: activity = rise | fall;
      DET_FALL: activity = fall;
      default: activity = both_levels;
    endcase
  end
  // Level mode forgets what it saw after each hit so a stuck input times out
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prev_ff <= 1'b0;
      seen_hi_ff <= 1'b0;
      seen_lo_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= ref_level;
      seen_hi_ff <= activity ? 1'b0 : (seen_hi_ff | ref_level);
      seen_lo_ff <= activity ? 1'b0 : (seen_lo_ff | ~ref_level);
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timer_ff <= '0;
      present_ff <= 1'b0;
    end else if (ce) begin
      if (activity) begin
        timer_ff <= DET_TIMER_W'(DET_WINDOW_CYC);
        present_ff <= 1'b1;
      end else if (timer_ff != '0) begin
        timer_ff <= timer_ff - 1'b1;
      end else begin
        present_ff <= 1'b0;
      end
    end
  end
  assign present = present_ff;
endmodule // ref_activity_detector

/* File: rtl/divdly_refdet_regs.sv */
// Divider dynamic delay enables and reference detect control register bank
`timescale 1ns/1ps
module divdly_refdet_regs import divdly_refdet_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic nv_load,
  input wire logic [7:0] nv_delay_image,
  input wire logic [7:0] nv_ref_det,
  input wire logic [DIV_COUNT*DIV_VALUE_W-1:0] div_values,
  input wire logic pri_ref_level,
  input wire logic sec_ref_level,
  output logic ch7_dynamic_delay_en,
  output logic ch6_dynamic_delay_en,
  output logic ch5_dynamic_delay_en,
  output logic ch4_dynamic_delay_en,
  output logic ch2_3_dynamic_delay_en,
  output logic ch0_1_dynamic_delay_en,
  output logic [DIV_COUNT-1:0] margin_permit,
  output logic [1:0] secondary_detector_method,
  output logic [1:0] primary_detector_method,
  output logic pri_ref_present,
  output logic sec_ref_present
);
  function automatic logic margin_ok(input logic en, input logic [DIV_VALUE_W-1:0] div);
    margin_ok = en & (div > MARGIN_MIN_DIV);
  endfunction

  logic [5:0] delay_en_ff;
  logic [1:0] sec_method_ff;
  logic [1:0] pri_method_ff;
  logic [DIV_COUNT-1:0] margin_ff;
  logic [7:0] rdata_ff;
  logic pri_present;
  logic sec_present;

  wire hit_dyn = (addr == DELAY_EN_OFS);
  wire hit_det = (addr == REF_DET_OFS);
  wire hit_sts = (addr == REF_STATUS_OFS);
  wire wr_dyn = wr_en & hit_dyn;
  wire wr_det = wr_en & hit_det;

  // Storage load wins over a bus write in the same cycle; it happens on any cycle with nv_load and ce high
  wire [5:0] nxt_delay_en = nv_load ? nv_delay_image[5:0] : wdata[5:0];
  wire [1:0] nxt_sec = nv_load ? nv_ref_det[SEC_METHOD_LSB +: 2] : wdata[SEC_METHOD_LSB +: 2];
  wire [1:0] nxt_pri = nv_load ? nv_ref_det[PRI_METHOD_LSB +: 2] : wdata[PRI_METHOD_LSB +: 2];

  // Reserved bits and unmapped addresses read as zero
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit_dyn) begin
      nxt_rdata = {2'b00, delay_en_ff};
    end else if (hit_det) begin
      nxt_rdata = {sec_method_ff, pri_method_ff, 4'h0};
    end else if (hit_sts) begin
      nxt_rdata = {6'h00, sec_present, pri_present};
    end
  end

  logic [DIV_COUNT-1:0] nxt_margin;
  always_comb begin
    for (int i = 0; i < DIV_COUNT; i++) begin
      nxt_margin[i] = margin_ok(delay_en_ff[i], div_values[i*DIV_VALUE_W +: DIV_VALUE_W]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      delay_en_ff <= DELAY_EN_RESET;
    end else if (ce && (nv_load || wr_dyn)) begin
      delay_en_ff <= nxt_delay_en;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_method_ff <= METHOD_RESET;
      pri_method_ff <= METHOD_RESET;
    end else if (ce && (nv_load || wr_det)) begin
      sec_method_ff <= nxt_sec;
      pri_method_ff <= nxt_pri;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      margin_ff <= '0;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      margin_ff <= nxt_margin;
      rdata_ff <= rd_en ? nxt_rdata : 8'h00;
    end
  end

  // Both detectors decode the same code set, so one module serves both inputs
  ref_activity_detector pri_det (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .ref_level(pri_ref_level),
    .method(pri_method_ff),
    .present(pri_present)
  );

  ref_activity_detector sec_det (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .ref_level(sec_ref_level),
    .method(sec_method_ff),
    .present(sec_present)
  );

  assign rdata = rdata_ff;
  assign ch7_dynamic_delay_en = delay_en_ff[5];
  assign ch6_dynamic_delay_en = delay_en_ff[4];
  assign ch5_dynamic_delay_en = delay_en_ff[3];
  assign ch4_dynamic_delay_en = delay_en_ff[2];
  assign ch2_3_dynamic_delay_en = delay_en_ff[1];
  assign ch0_1_dynamic_delay_en = delay_en_ff[0];
  assign margin_permit = margin_ff;
  assign secondary_detector_method = sec_method_ff;
  assign primary_detector_method = pri_method_ff;
  assign pri_ref_present = pri_present;
  assign sec_ref_present = sec_present;
endmodule // divdly_refdet_regs

/* File: verification/divdly_refdet_sva.sv */
// Assertions for the divider delay and reference detect register bank
`timescale 1ns/1ps
module divdly_refdet_sva import divdly_refdet_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic nv_load,
  input wire logic [7:0] nv_delay_image,
  input wire logic [7:0] nv_ref_det,
  input wire logic [DIV_COUNT*DIV_VALUE_W-1:0] div_values,
  input wire logic pri_ref_level,
  input wire logic ch7_dynamic_delay_en,
  input wire logic ch6_dynamic_delay_en,
  input wire logic ch5_dynamic_delay_en,
  input wire logic ch4_dynamic_delay_en,
  input wire logic ch2_3_dynamic_delay_en,
  input wire logic ch0_1_dynamic_delay_en,
  input wire logic [DIV_COUNT-1:0] margin_permit,
  input wire logic [1:0] secondary_detector_method,
  input wire logic [1:0] primary_detector_method,
  input wire logic pri_ref_present
);
  logic [5:0] en;
  logic [5:0] gt;
  logic [3:0] md;
  assign en = {ch7_dynamic_delay_en, ch6_dynamic_delay_en, ch5_dynamic_delay_en,
    ch4_dynamic_delay_en, ch2_3_dynamic_delay_en, ch0_1_dynamic_delay_en};
  assign md = {secondary_detector_method, primary_detector_method};
  always_comb for (int i = 0; i < 6; i++) gt[i] = div_values[8*i+:8] > MARGIN_MIN_DIV;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence rd(a); ce && rd_en && addr == a; endsequence
  sequence wr(a); ce && wr_en && !nv_load && addr == a; endsequence
  AST_RD_DLY: assert property (rd(8'h18) |=> rdata == {2'h0, $past(en)})
    else $error("delay readback wrong");
  AST_RD_DET: assert property (rd(8'h19) |=> rdata == {$past(md), 4'h0})
    else $error("detect readback wrong");
  AST_WR_DLY: assert property (wr(8'h18) |=> en == $past(wdata[5:0]))
    else $error("delay write wrong");
  AST_WR_DET: assert property (wr(8'h19) |=> md == $past(wdata[7:4]))
    else $error("method write wrong");
  AST_NV: assert property (ce && nv_load |=> en == $past(nv_delay_image[5:0])
    && md == $past(nv_ref_det[7:4])) else $error("storage load wrong");
  AST_HOLD: assert property (!(ce && (wr_en || nv_load)) |=> $stable(en) && $stable(md))
    else $error("field changed unasked");
  AST_MARGIN: assert property (ce |=> margin_permit == $past(en & gt))
    else $error("margin permit wrong");
  AST_IDLE: assert property (ce && !rd_en |=> rdata == 8'h00)
    else $error("idle read data not zero");
  AST_DET: assert property (ce && primary_detector_method == 2'h0
    && $rose(pri_ref_level) |=> pri_ref_present) else $error("rising edge not seen");
endmodule // divdly_refdet_sva
bind divdly_refdet_regs divdly_refdet_sva chk (.*);

/* File: verification/divdly_refdet_regs_tb.sv */
// Self-checking bench for the divider delay and reference detect register bank
`timescale 1ns/1ps
module divdly_refdet_regs_tb;
  logic ref_clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, nv_load = 1'b0, pl = 1'b0;
  logic [7:0] addr = '0, wdata = '0, rdata, nvd = '0, nvr = '0, d;
  logic [47:0] dv = '0;
  logic [5:0] en, mp;
  logic pp, sp;
  logic sl = 1'b0;
  logic [31:0] seed = 32'h9E81;
  int bad_count = 0, checks = 0;
  always #4 ref_clk = ~ref_clk;
  divdly_refdet_regs DUT (.ref_clk, .nrst, .ce(1'b1), .addr, .wdata, .wr_en, .rd_en, .rdata,
    .nv_load, .nv_delay_image(nvd), .nv_ref_det(nvr), .div_values(dv), .pri_ref_level(pl),
    .sec_ref_level(sl), .ch7_dynamic_delay_en(en[5]), .ch6_dynamic_delay_en(en[4]),
    .ch5_dynamic_delay_en(en[3]), .ch4_dynamic_delay_en(en[2]),
    .ch2_3_dynamic_delay_en(en[1]), .ch0_1_dynamic_delay_en(en[0]), .margin_permit(mp),
    .secondary_detector_method(), .primary_detector_method(), .pri_ref_present(pp),
    .sec_ref_present(sp));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] mexp(logic [5:0] e, logic [47:0] v);
    mexp = 8'h00;
    for (int i = 0; i < 6; i++) mexp[i] = e[i] && v[8*i+:8] > 8'h08;
  endfunction
  task chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task conclude;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h50);
    for (int i = 0; i < 24; i++) begin
      d = 8'(rnd());
      // First passes walk every method code with reserved bits set
      if (i < 4) d = {i[1:0], i[1:0], 4'hF};
      wr(8'h18, d);
      rd(8'h18, {2'h0, d[5:0]});
      wr(8'h19, d);
      rd(8'h19, {d[7:4], 4'h0});
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    @(posedge ref_clk);
    nvd <= 8'(rnd());
    nvr <= 8'(rnd());
    nv_load <= 1'b1;
    @(posedge ref_clk);
    nv_load <= 1'b0;
    rd(8'h18, {2'h0, nvd[5:0]});
    rd(8'h19, {nvr[7:4], 4'h0});
    for (int i = 0; i < 8; i++) begin
      d = 8'(rnd());
      wr(8'h18, d);
      dv <= {8'h08, 8'h09, seed};
      repeat (2) @(posedge ref_clk);
      #1 chk("margin", mexp(d[5:0], dv), {2'h0, mp});
    end
    wr(8'h19, 8'h00);
    pl <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("present", 8'h01, {7'h0, pp});
    repeat (70) @(posedge ref_clk);
    #1 chk("absent", 8'h00, {6'h0, sp, pp});
    // Secondary on falling edges, primary on level detection
    wr(8'h19, 8'hB0);
    sl <= 1'b1;
    @(posedge ref_clk);
    pl <= 1'b0;
    sl <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("present2", 8'h03, {6'h0, sp, pp});
    conclude();
  end
endmodule // divdly_refdet_regs_tb
